// >>> verilog/pdwk_power_ctrl.sv
// Purpose: Power-down entry, wake-up flag, wake delay and oscillator enables, over APB.
// Assumes: Wake events and core sleep are synchronous to sys_clk; count enables are pulses.
// Notes:   Control word at 0x000, unlock byte at 0x004, state at 0x008.
`timescale 1ns/1ps
`default_nettype none
`include "pdwk_defs.svh"

// Summary of operation
// - Read of sleep enable shows pending or active power-down; zero when running or idle.
// - Any wake event during power-down sets the wake flag, bit 6.
// - Writing one to the wake flag clears it; writing zero leaves it.
// - Wake interrupt is high while wake flag and its enable, bit 5, are high.
// - Bit 4 enables holding the system clock for a delay after wake-up.
// - Delay is 4096 cycles on the main crystal, 256 on the fast oscillator.
// - Bit 3 runs or stops the low-frequency oscillator.
// - Bit 2 runs or stops the high-speed oscillator.
// - Bit 1 enables or disables the watch crystal.
// - Bit 0 enables main crystal; reset value from configuration, forced for crystal source.
// - Sleep enable and wait bit clear: core sleep stops only the core clock.
// - Sleep enable set, wait bit clear: power down at once, low-frequency sources run.
// - Sleep enable and wait bit set: power down once the core sleeps.
// - Enable bits and wait bit accept writes only while protection is unlocked.
// - Sleep enable clears itself on wake-up.
// - Power-down stops main crystal, fast oscillator, PLL and system clock.
module pdwk_power_ctrl
    import pdwk_pkg::*;
(
    // Clock and reset.
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    // APB slave.
    input  wire pdwk_pkg::pdwk_apb_req_t apb_req,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Core and wake sources.
    input  wire logic          core_sleep,
    input  wire logic [7:0]    wake_events,
    // Configuration and clock source.
    input  wire logic [2:0]    user_cfg_clk_src,
    input  wire logic          sys_on_main_xtl,
    input  wire logic          xtl_cycle_en,
    input  wire logic          rc_cycle_en,
    // Clock controls and interrupt.
    output pdwk_pkg::pdwk_clk_ctl_t clk_ctl,
    output logic               wakeup_irq
);
    import pdwk_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        pdwk_state_t state;
        pdwk_lock_t  lock;
        logic        strap_done;
        logic        wait_for_core_sleep;
        logic        sleep_request_enable;
        logic        wakeup_status_flag;
        logic        wakeup_irq_enable;
        logic        wakeup_delay_enable;
        logic        low_freq_rc_enable;
        logic        high_speed_rc_enable;
        logic        watch_crystal_enable;
        logic        main_crystal_enable;
        logic [31:0] rdata;
    } pdwk_st_t;

    pdwk_st_t s_q;
    pdwk_st_t s_d;

    logic        wr_acc;
    logic        rd_acc;
    logic        hit_ctrl;
    logic        hit_prot;
    logic        hit_stat;
    logic        dly_start;
    logic        dly_busy;
    logic        dly_done;
    logic        dly_tick;
    logic [12:0] dly_term;
    logic        enter_down;
    logic        wake;
    logic [31:0] ctrl_word;

    assign wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_acc   = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign hit_ctrl = apb_req.paddr == `PDWK_OFS_CTRL;
    assign hit_prot = apb_req.paddr == `PDWK_OFS_PROT;
    assign hit_stat = apb_req.paddr == `PDWK_OFS_STAT;
    assign pready   = 1'b1;
    assign pslverr  = apb_req.psel && apb_req.penable && !(hit_ctrl || hit_prot || hit_stat);

    // Power-down entry follows the mode table.
    assign enter_down = s_q.sleep_request_enable && (!s_q.wait_for_core_sleep || core_sleep);
    assign wake       = |wake_events;

    // Delay length depends on the source the system clock runs from.
    assign dly_term = sys_on_main_xtl ? `PDWK_DLY_XTL_CYC : `PDWK_DLY_RC_CYC;
    assign dly_tick = sys_on_main_xtl ? xtl_cycle_en : rc_cycle_en;
    assign dly_start = (s_q.state == PDWK_ST_DOWN) && wake && s_q.wakeup_delay_enable;

    assign ctrl_word = {23'h000000, s_q.wait_for_core_sleep,
                        (s_q.sleep_request_enable || s_q.state == PDWK_ST_DOWN),
                        s_q.wakeup_status_flag, s_q.wakeup_irq_enable, s_q.wakeup_delay_enable,
                        s_q.low_freq_rc_enable, s_q.high_speed_rc_enable,
                        s_q.watch_crystal_enable, s_q.main_crystal_enable};

    pdwk_delay_counter u_delay (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .start    (dly_start),
        .count_en (dly_tick),
        .terminal (dly_term),
        .busy     (dly_busy),
        .done     (dly_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d = s_q;
        // Catch the configured crystal default once, after reset release.
        if (!s_q.strap_done)
        begin
            s_d.strap_done          = 1'b1;
            s_d.main_crystal_enable = (user_cfg_clk_src == `PDWK_CFG_SRC_XTL);
        end
        if (rd_acc)
        begin
            if (hit_ctrl)
                s_d.rdata = ctrl_word;
            else if (hit_prot)
                s_d.rdata = {31'h00000000, s_q.lock == PDWK_LK_OPEN};
            else if (hit_stat)
                s_d.rdata = {30'h00000000, s_q.state};
            else
                s_d.rdata = 32'h00000000;
        end
        if (wr_acc && hit_prot)
        begin
            case (s_q.lock)
                PDWK_LK_LOCKED: s_d.lock = (apb_req.pwdata[7:0] == `PDWK_UNLOCK_B0)
                                         ? PDWK_LK_GOT1 : PDWK_LK_LOCKED;
                PDWK_LK_GOT1:   s_d.lock = (apb_req.pwdata[7:0] == `PDWK_UNLOCK_B1)
                                         ? PDWK_LK_GOT2 : PDWK_LK_LOCKED;
                PDWK_LK_GOT2:   s_d.lock = (apb_req.pwdata[7:0] == `PDWK_UNLOCK_B2)
                                         ? PDWK_LK_OPEN : PDWK_LK_LOCKED;
                default:        s_d.lock = PDWK_LK_LOCKED;
            endcase
        end
        if (wr_acc && hit_ctrl)
        begin
            if (apb_req.pwdata[`PDWK_BIT_WU_FLAG])
                s_d.wakeup_status_flag = 1'b0;
            if (s_q.lock == PDWK_LK_OPEN)
            begin
                s_d.wait_for_core_sleep  = apb_req.pwdata[`PDWK_BIT_WAIT_CORE];
                s_d.sleep_request_enable = apb_req.pwdata[`PDWK_BIT_SLEEP_EN];
                s_d.wakeup_irq_enable    = apb_req.pwdata[`PDWK_BIT_WU_IRQ_EN];
                s_d.wakeup_delay_enable  = apb_req.pwdata[`PDWK_BIT_WU_DLY_EN];
                s_d.low_freq_rc_enable   = apb_req.pwdata[`PDWK_BIT_LF_RC];
                s_d.high_speed_rc_enable = apb_req.pwdata[`PDWK_BIT_HS_RC];
                s_d.watch_crystal_enable = apb_req.pwdata[`PDWK_BIT_WATCH_XTL];
                s_d.main_crystal_enable  = apb_req.pwdata[`PDWK_BIT_MAIN_XTL]
                    || (user_cfg_clk_src == `PDWK_CFG_SRC_XTL);
            end
        end
        case (s_q.state)
            PDWK_ST_RUN:
            begin
                if (enter_down)
                    s_d.state = PDWK_ST_DOWN;
            end
            PDWK_ST_DOWN:
            begin
                if (wake)
                begin
                    s_d.wakeup_status_flag   = 1'b1;
                    s_d.sleep_request_enable = 1'b0;
                    s_d.state = s_q.wakeup_delay_enable ? PDWK_ST_WAKE : PDWK_ST_RUN;
                end
            end
            PDWK_ST_WAKE:
            begin
                if (dly_done)
                    s_d.state = PDWK_ST_RUN;
            end
            default:
                s_d.state = PDWK_ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q      <= '0;
            s_q.lock <= PDWK_LK_LOCKED;
            {s_q.wait_for_core_sleep, s_q.sleep_request_enable, s_q.wakeup_status_flag,
             s_q.wakeup_irq_enable, s_q.wakeup_delay_enable, s_q.low_freq_rc_enable,
             s_q.high_speed_rc_enable, s_q.watch_crystal_enable,
             s_q.main_crystal_enable} <= `PDWK_RST_CTRL;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata     = s_q.rdata;
    assign wakeup_irq = s_q.wakeup_status_flag && s_q.wakeup_irq_enable;

    always_comb
    begin
        clk_ctl.lf_rc_en     = s_q.low_freq_rc_enable;
        clk_ctl.watch_xtl_en = s_q.watch_crystal_enable;
        clk_ctl.main_xtl_en  = s_q.main_crystal_enable && s_q.state != PDWK_ST_DOWN;
        clk_ctl.hs_rc_en     = s_q.high_speed_rc_enable && s_q.state != PDWK_ST_DOWN;
        clk_ctl.pll_en       = s_q.state != PDWK_ST_DOWN;
        clk_ctl.sys_clk_en   = s_q.state == PDWK_ST_RUN;
        // Idle: core sleeping without a power-down request stops only the core clock.
        clk_ctl.cpu_clk_en   = s_q.state == PDWK_ST_RUN
                               && !(core_sleep && !s_q.sleep_request_enable);
    end

    ////////////////////////////////////////////////////////////////////////////
    a_wake_sets_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_DOWN && wake |=> s_q.wakeup_status_flag)
        else $error("wake did not set flag");
    a_w1c_clears_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_acc && hit_ctrl && apb_req.pwdata[6] && s_q.state != PDWK_ST_DOWN
        |=> !s_q.wakeup_status_flag)
        else $error("flag not cleared by write one");
    a_irq_tracks_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wakeup_irq == (s_q.wakeup_status_flag && s_q.wakeup_irq_enable))
        else $error("irq mismatch");
    a_locked_no_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_acc && hit_ctrl && s_q.lock != PDWK_LK_OPEN && s_q.state == PDWK_ST_RUN
        |=> $stable(s_q.low_freq_rc_enable) && $stable(s_q.wakeup_irq_enable))
        else $error("protected bit written while locked");
    a_down_at_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_RUN && s_q.sleep_request_enable && !s_q.wait_for_core_sleep
        |=> s_q.state == PDWK_ST_DOWN)
        else $error("power-down not entered");
    a_wait_core: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_RUN && s_q.wait_for_core_sleep && !core_sleep
        |=> s_q.state == PDWK_ST_RUN)
        else $error("entered power-down before core sleep");
    a_wake_clears_en: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_DOWN && wake |=> !s_q.sleep_request_enable)
        else $error("sleep enable not cleared on wake");
    a_down_stops_fast: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_DOWN |-> !clk_ctl.main_xtl_en && !clk_ctl.hs_rc_en
        && !clk_ctl.pll_en && !clk_ctl.sys_clk_en)
        else $error("fast clocks running in power-down");
    a_read_enable: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_DOWN |-> ctrl_word[7])
        else $error("sleep enable reads zero in power-down");
    a_delay_gates: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_WAKE |-> !clk_ctl.sys_clk_en)
        else $error("system clock released during delay");

    c_enter_down: cover property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_RUN ##1 s_q.state == PDWK_ST_DOWN);
    c_wake_delay: cover property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.state == PDWK_ST_WAKE ##1 s_q.state == PDWK_ST_RUN);
    c_unlock: cover property (@(posedge sys_clk) disable iff (!arst_n)
        s_q.lock == PDWK_LK_OPEN);
    c_irq: cover property (@(posedge sys_clk) disable iff (!arst_n) wakeup_irq);
endmodule
`default_nettype wire

// >>> verilog/pdwk_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the power-down control.
// Assumes: 32-bit APB data, one word per register.
// Notes:   Definitions only.
`ifndef PDWK_DEFS_SVH
`define PDWK_DEFS_SVH

`define PDWK_OFS_CTRL        12'h000
`define PDWK_OFS_PROT        12'h004
`define PDWK_OFS_STAT        12'h008

`define PDWK_BIT_WAIT_CORE   8
`define PDWK_BIT_SLEEP_EN    7
`define PDWK_BIT_WU_FLAG     6
`define PDWK_BIT_WU_IRQ_EN   5
`define PDWK_BIT_WU_DLY_EN   4
`define PDWK_BIT_LF_RC       3
`define PDWK_BIT_HS_RC       2
`define PDWK_BIT_WATCH_XTL   1
`define PDWK_BIT_MAIN_XTL    0

`define PDWK_RST_CTRL        9'h01c

`define PDWK_UNLOCK_B0       8'h59
`define PDWK_UNLOCK_B1       8'h16
`define PDWK_UNLOCK_B2       8'h88

`define PDWK_CFG_SRC_XTL     3'h0

`define PDWK_DLY_XTL_CYC     13'd4096
`define PDWK_DLY_RC_CYC      13'd256

`endif

// >>> verilog/pdwk_pkg.sv
// Purpose: Types shared by the power-down control block.
// Assumes: Nothing beyond the header of constants.
// Notes:   Its only numbers are the state and lock encodings.
package pdwk_pkg;

    typedef enum logic [1:0] {
        PDWK_ST_RUN   = 2'b00,
        PDWK_ST_DOWN  = 2'b01,
        PDWK_ST_WAKE  = 2'b10
    } pdwk_state_t;

    typedef enum logic [1:0] {
        PDWK_LK_LOCKED = 2'b00,
        PDWK_LK_GOT1   = 2'b01,
        PDWK_LK_GOT2   = 2'b10,
        PDWK_LK_OPEN   = 2'b11
    } pdwk_lock_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pdwk_apb_req_t;

    typedef struct packed {
        logic        cpu_clk_en;
        logic        sys_clk_en;
        logic        pll_en;
        logic        main_xtl_en;
        logic        hs_rc_en;
        logic        watch_xtl_en;
        logic        lf_rc_en;
    } pdwk_clk_ctl_t;

endpackage

// >>> verilog/pdwk_delay_counter.sv
// Purpose: Wake-up stabilisation counter for the power-down control.
// Assumes: start is a one-cycle pulse; count_en marks cycles of the selected source.
// Notes:   done pulses for one cycle when the terminal count is reached.
`timescale 1ns/1ps
`default_nettype none
module pdwk_delay_counter
    import pdwk_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Control.
    input  wire logic        start,
    input  wire logic        count_en,
    input  wire logic [12:0] terminal,
    // Status.
    output logic             busy,
    output logic             done
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [12:0] cnt;
    } pdwk_dly_st_t;

    pdwk_dly_st_t s_q;
    pdwk_dly_st_t s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (start)
        begin
            s_d.busy = 1'b1;
            s_d.cnt  = 13'h0000;
        end
        else if (s_q.busy && count_en)
        begin
            if (s_q.cnt == terminal - 13'h0001)
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            s_d.cnt = s_q.cnt + 13'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = s_q.busy;
    assign done = s_q.done;

    a_dly_start_busy: assert property (@(posedge sys_clk) disable iff (!arst_n)
        start |=> busy && !done) else $error("delay counter not busy after start");
endmodule
`default_nettype wire

// >>> verif/pdwk_core_model.sv
// Purpose: Processor core and wake sources that face the power-down control.
// Assumes: Commands from the bench are synchronous to sys_clk.
// Notes:   Cycle marks come every cycle, or every second cycle while slow is set.
`timescale 1ns/1ps
`default_nettype none
module pdwk_core_model
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Commands from the bench.
    input  wire logic       wfi_cmd,
    input  wire logic [7:0] wake_cmd,
    input  wire logic       slow,
    // Toward the block.
    output logic            core_sleep,
    output logic [7:0]      wake_events,
    output logic            xtl_cycle_en,
    output logic            rc_cycle_en
);
    logic phase_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_q     <= 1'b0;
            core_sleep  <= 1'b0;
            wake_events <= 8'h00;
        end
        else
        begin
            phase_q     <= ~phase_q;
            core_sleep  <= wfi_cmd;
            wake_events <= wake_cmd;
        end
    end

    // Both sources are marked alike, so the block must pick the one it runs from.
    assign xtl_cycle_en = arst_n & (~slow | phase_q);
    assign rc_cycle_en  = xtl_cycle_en;
endmodule
`default_nettype wire

// >>> verif/power_down_wakeup_control_test.sv
// Purpose: Self-checking bench of the power-down control.
// Assumes: Zero-wait APB slave; wake events act only while powered down.
// Notes:   The default clock source is the main crystal.
`timescale 1ns/1ps
`default_nettype none
`include "pdwk_defs.svh"
module power_down_wakeup_control_test;
    import pdwk_pkg::*;
    logic          sys_clk  = 1'b0;
    logic          arst_n   = 1'b0;
    pdwk_apb_req_t req      = '0;
    logic [7:0]    wake_cmd = 8'h00;
    logic          wfi_cmd  = 1'b0;
    logic          slow     = 1'b0;
    logic          on_xtl   = 1'b1;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          core_sleep;
    logic [7:0]    wake_events;
    logic          xtl_cycle_en;
    logic          rc_cycle_en;
    logic          wakeup_irq;
    pdwk_clk_ctl_t clk_ctl;
    logic [31:0]   rd;
    logic          err;
    int            errors   = 0;
    int            compares = 0;

    always #4 sys_clk = ~sys_clk;

    pdwk_power_ctrl i_pdwk_power_ctrl (
        .sys_clk(sys_clk), .arst_n(arst_n), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_sleep(core_sleep),
        .wake_events(wake_events), .user_cfg_clk_src(`PDWK_CFG_SRC_XTL),
        .sys_on_main_xtl(on_xtl), .xtl_cycle_en(xtl_cycle_en), .rc_cycle_en(rc_cycle_en),
        .clk_ctl(clk_ctl), .wakeup_irq(wakeup_irq));

    pdwk_core_model i_pdwk_core_model (
        .sys_clk(sys_clk), .arst_n(arst_n), .wfi_cmd(wfi_cmd), .wake_cmd(wake_cmd),
        .slow(slow), .core_sleep(core_sleep), .wake_events(wake_events),
        .xtl_cycle_en(xtl_cycle_en), .rc_cycle_en(rc_cycle_en));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic int dly_cycles(input logic xtl, input logic slw);
        return (xtl ? int'(`PDWK_DLY_XTL_CYC) : int'(`PDWK_DLY_RC_CYC)) * (slw ? 2 : 1);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge sys_clk);
        end
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        req <= '0;
        @(posedge sys_clk);
    endtask

    task automatic wait_sys(input logic v, input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (clk_ctl.sys_clk_en !== v && n < lim);
    endtask

    task automatic results;
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        results();
    end

    initial
    begin
        int          n;
        int          e;
        logic [31:0] v;
        logic [31:0] cfg;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        void'($urandom(47940));
        apb(0, `PDWK_OFS_CTRL, 0);
        chk("ctrl reset", {23'h0, `PDWK_RST_CTRL} | 32'h1, rd);
        apb(1, `PDWK_OFS_CTRL, 32'h0);
        apb(0, `PDWK_OFS_CTRL, 0);
        chk("locked ctrl", {23'h0, `PDWK_RST_CTRL} | 32'h1, rd);
        apb(0, 12'h00c, 0);
        chk("unmapped error", 1, err);
        apb(1, `PDWK_OFS_PROT, {24'h0, `PDWK_UNLOCK_B0});
        apb(1, `PDWK_OFS_PROT, {24'h0, `PDWK_UNLOCK_B1});
        apb(1, `PDWK_OFS_PROT, {24'h0, `PDWK_UNLOCK_B2});
        repeat (6)
        begin
            v = $urandom & 32'h3f;
            apb(1, `PDWK_OFS_CTRL, v);
            apb(0, `PDWK_OFS_CTRL, 0);
            // The configuration selects the main crystal, so its enable reads back forced on.
            chk("ctrl readback", v | 32'h1, rd);
            chk("lf rc", v[3], clk_ctl.lf_rc_en);
            chk("hs rc", v[2], clk_ctl.hs_rc_en);
            chk("watch xtl", v[1], clk_ctl.watch_xtl_en);
            chk("main xtl", 1, clk_ctl.main_xtl_en);
        end
        for (int k = 0; k < 3; k++)
        begin
            on_xtl <= (k == 0);
            slow <= (k == 1);
            cfg = {26'h0, k != 2, k < 2, 4'hf};
            apb(1, `PDWK_OFS_CTRL, cfg);
            apb(1, `PDWK_OFS_CTRL, cfg | 32'h80);
            apb(0, `PDWK_OFS_CTRL, 0);
            chk("sleep read", 1, rd[7]);
            chk("sys clock", 0, clk_ctl.sys_clk_en);
            chk("fast sources", 0, {clk_ctl.main_xtl_en, clk_ctl.hs_rc_en, clk_ctl.pll_en});
            chk("slow sources", 2'b11, {clk_ctl.watch_xtl_en, clk_ctl.lf_rc_en});
            wake_cmd <= 8'h01 << ($urandom % 8);
            @(posedge sys_clk);
            wake_cmd <= 8'h00;
            wait_sys(1, 9000, n);
            e = (k < 2) ? dly_cycles(k == 0, k == 1) : 0;
            chk("wake delay", 1, n >= e && n <= e + 6);
            apb(0, `PDWK_OFS_CTRL, 0);
            chk("flag and sleep", 2'b01, rd[7:6]);
            chk("irq", k != 2, wakeup_irq);
            apb(1, `PDWK_OFS_CTRL, cfg);
            apb(0, `PDWK_OFS_CTRL, 0);
            chk("flag kept", 1, rd[6]);
            apb(1, `PDWK_OFS_CTRL, cfg | 32'h40);
            apb(0, `PDWK_OFS_CTRL, 0);
            chk("flag cleared", 0, rd[6]);
            chk("irq cleared", 0, wakeup_irq);
        end
        apb(1, `PDWK_OFS_CTRL, 32'h18f);
        apb(0, `PDWK_OFS_CTRL, 0);
        chk("pending read", 1, rd[7]);
        chk("clock before core sleep", 1, clk_ctl.sys_clk_en);
        wfi_cmd <= 1'b1;
        wait_sys(0, 8, n);
        chk("deep sleep", 0, clk_ctl.sys_clk_en);
        wake_cmd <= 8'h80;
        @(posedge sys_clk);
        wake_cmd <= 8'h00;
        wait_sys(1, 8, n);
        chk("woken", 1, clk_ctl.sys_clk_en);
        apb(1, `PDWK_OFS_CTRL, 32'h4f);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("idle core clock", 0, clk_ctl.cpu_clk_en);
        chk("idle sys clock", 1, clk_ctl.sys_clk_en);
        apb(0, `PDWK_OFS_CTRL, 0);
        chk("idle read", 0, rd[7]);
        wfi_cmd <= 1'b0;
        results();
    end
endmodule
`default_nettype wire
